// ---- hdl/reset_sources.sv ----
/*
 * Reset source combiner with cause flags and a command-coded watchdog.
 * Assumes synchronous inputs, the system clock seen as a one-cycle
 * tick on the reference clock, and an open-drain reset pin resolved
 * outside this module.
 */
// Chosen here: register access over Wishbone and the register offsets.
// Function
// - Supply low drives pin and core reset
// - Supply recovery releases like power-on
// - Pin low resets; hold twelve cycles after
// - Pin reset sets flag bit zero
// - No clock tick for limit gives reset
// - Clock-loss flag bit two; pin undriven
// - Clock-loss detector runs only when enabled
// - Enabled comparator low output causes reset
// - Comparator flag reads one; pin undriven
// - Comparator reset path needs no clock
// - Enabled convert-start low holds reset, level
// - Convert-start flag reads one; pin undriven
// - Twenty-one bit watchdog overflow resets core
// - Watchdog enabled, longest interval after reset
// - Code A5 enables and restarts watchdog
// - DE then AD within four disables
// - Code FF locks out disable until reset
// - Timeout is four to three plus interval
// - Watchdog control read returns interval
// - Supply reset holds pin low for timeout
// - Power-on flag set; other resets clear
// - Writing power flag forces power-on sequence
`timescale 1ns/1ns
`default_nettype none
module reset_sources #(
   parameter int SUPPLY_TICKS = reset_pkg::SUPPLY_CYCLES,   // Supply wait
   parameter int LOSS_TICKS   = reset_pkg::CLK_LOSS_CYCLES  // Clock-loss
) (
   input  wire logic              clock,          // Reference clock
   input  wire logic              rst,            // Power-on, async high
   input  wire reset_pkg::wb_req_t wbReq,         // Wishbone request
   output reset_pkg::wb_rsp_t     wbRsp,          // Wishbone answer
   input  wire logic              sysClkTick,     // System clock edge
   input  wire logic              supplyLow,      // Supply below threshold
   input  wire logic              rstPinIn,       // Reset pin level
   output logic                   rstPinOut,      // Pin drive value
   output logic                   rstPinOe,       // Pin drive enable
   input  wire logic              compPlusBelow,  // Comparator plus < minus
   input  wire logic              convStartIn,    // Convert-start pin level
   output logic                   coreReset       // Controller reset
);
   // Counter widths
   localparam int SUP_W  = $clog2(SUPPLY_TICKS + 1);
   localparam int LOSS_W = $clog2(LOSS_TICKS + 1);
   localparam int WB     = reset_pkg::WDT_BITS;

   // Elaboration checks
   if (SUPPLY_TICKS < 1 || LOSS_TICKS < 2) begin : g_bad_param
      $error("Timeout parameters too small");
   end

   // Whole state of the block
   typedef struct packed {
      reset_pkg::phase_t phase;  // Running or held in reset
      logic [SUP_W-1:0]  supCnt; // Supply timeout remaining
      logic [3:0]        pinCnt; // Pin release hold remaining
      logic [3:0]        evtCnt; // Hold for pulsed sources
      logic [LOSS_W-1:0] lossCnt;// Cycles since last system tick
      logic [WB-1:0]     wdtCnt; // Watchdog count
      logic              wdtEn;  // Watchdog running
      logic              wdtLock;// Disable locked out
      logic [2:0]        armCnt; // Disable window remaining
      logic [2:0]        interval;// Watchdog interval field
      logic              compEn; // Comparator reset enable
      logic              cnvEn;  // Convert-start reset enable
      logic              detEn;  // Clock-loss detect enable
      logic [7:0]        flags;  // Cause of last reset
      logic [7:0]        pend;   // Causes seen in current reset
      logic              ack;    // Bus acknowledge
      logic [31:0]       rdData; // Bus read data
   } state_t;

   state_t st_q;   // Registered state
   state_t st_d;   // Next state

   // Timeout in ticks minus one for an interval field
   function automatic logic [WB-1:0] wdtLast(input logic [2:0] n);
      logic [WB-1:0] one;
      one = {{(WB-1){1'b0}}, 1'b1};
      wdtLast = (one << (2 * (reset_pkg::WDT_BASE_EXP + int'(n)))) - one;
   endfunction

   // Source and event terms
   logic          pinDriven;   // This block pulls the pin low
   logic          pinLow;      // Pin held low by someone else
   logic          cmpReset;    // Unclocked comparator reset
   logic          cnvReset;    // Convert-start level reset
   logic          lossEvt;     // Clock-loss timeout pulse
   logic          wdtEvt;      // Watchdog overflow pulse
   logic [7:0]    srcNow;      // Active sources this cycle
   logic          busHit;      // Bus access this cycle
   logic          wrByte;      // Byte write to lane zero
   logic [7:0]    wrData;      // Written byte

   // Pin and level sources
   assign pinDriven = (st_q.supCnt != '0);
   assign pinLow    = ~rstPinIn & ~pinDriven;
   assign cmpReset  = st_q.compEn & compPlusBelow;
   assign cnvReset  = st_q.cnvEn & ~convStartIn;
   // Detector fires after the limit with no tick
   assign lossEvt   = st_q.detEn & ~sysClkTick &
      (st_q.lossCnt == LOSS_W'(LOSS_TICKS - 1));
   // Overflow at the programmed interval
   assign wdtEvt    = st_q.wdtEn & sysClkTick &
      (st_q.wdtCnt == wdtLast(st_q.interval));

   // Bus decode
   assign busHit = wbReq.cyc & wbReq.stb & ~st_q.ack;
   assign wrByte = busHit & wbReq.we & wbReq.sel[0];
   assign wrData = wbReq.dat[7:0];

   // Cause vector for this cycle
   always_comb begin
      srcNow = 8'h00;
      srcNow[reset_pkg::BIT_PIN_FLAG]   = pinLow | (st_q.pinCnt != 4'h0);
      srcNow[reset_pkg::BIT_POWER_FLAG] = supplyLow | pinDriven;
      srcNow[reset_pkg::BIT_CLKLOSS]    = lossEvt;
      srcNow[reset_pkg::BIT_WATCHDOG]   = wdtEvt;
      srcNow[reset_pkg::BIT_COMPARATOR] = cmpReset;
      srcNow[reset_pkg::BIT_CONVERT]    = cnvReset;
   end

   // Next-state logic
   always_comb begin
      logic anySrc;
      logic inRst;
      anySrc = (srcNow != 8'h00) | (st_q.evtCnt != 4'h0);
      inRst  = (st_q.phase == reset_pkg::PH_RESET);
      st_d   = st_q;

      // Supply monitor reloads timeout while low
      if (supplyLow) begin
         st_d.supCnt = SUP_W'(SUPPLY_TICKS);
      end else if (pinDriven) begin
         st_d.supCnt = st_q.supCnt - 1'b1;
      end

      // Pin hold counter
      if (pinLow) begin
         st_d.pinCnt = reset_pkg::PIN_HOLD;
      end else if (st_q.pinCnt != 4'h0) begin
         st_d.pinCnt = st_q.pinCnt - 4'h1;
      end

      // Pulsed sources stretched to a held reset
      if (lossEvt | wdtEvt) begin
         st_d.evtCnt = reset_pkg::PIN_HOLD;
      end else if (st_q.evtCnt != 4'h0) begin
         st_d.evtCnt = st_q.evtCnt - 4'h1;
      end

      // Clock-loss one-shot retriggered by each tick
      if (!st_q.detEn || sysClkTick || lossEvt) begin
         st_d.lossCnt = '0;
      end else begin
         st_d.lossCnt = st_q.lossCnt + 1'b1;
      end

      // Watchdog count and disable window
      if (st_q.wdtEn && sysClkTick) begin
         st_d.wdtCnt = st_q.wdtCnt + 1'b1;
      end
      if (st_q.armCnt != 3'h0) begin
         st_d.armCnt = st_q.armCnt - 3'h1;
      end

      // Bus answer: registered ack one cycle after the strobe, unmapped reads zero
      st_d.ack    = busHit;
      st_d.rdData = 32'h0000_0000;
      if (busHit && !wbReq.we) begin
         case (wbReq.adr)
            reset_pkg::OFS_WATCHDOG_CONTROL: begin
               st_d.rdData = {29'h0, st_q.interval};
            end
            reset_pkg::OFS_RESET_SOURCE: begin
               st_d.rdData = {24'h0, st_q.flags};
            end
            reset_pkg::OFS_OSCILLATOR_CTRL: begin
               st_d.rdData[reset_pkg::BIT_CLK_DET_EN] = st_q.detEn;
            end
            default: begin
               st_d.rdData = 32'h0000_0000;
            end
         endcase
      end

      // Register writes
      if (wrByte) begin
         case (wbReq.adr)
            reset_pkg::OFS_WATCHDOG_CONTROL: begin
               if (wrData == reset_pkg::WDT_RESTART) begin
                  st_d.wdtEn  = 1'b1;
                  st_d.wdtCnt = '0;
               end else if (wrData == reset_pkg::WDT_DIS_1) begin
                  st_d.armCnt = reset_pkg::DISABLE_WINDOW;
               end else if (wrData == reset_pkg::WDT_DIS_2) begin
                  if (st_q.armCnt != 3'h0 && !st_q.wdtLock) begin
                     st_d.wdtEn = 1'b0;
                  end
                  st_d.armCnt = 3'h0;
               end else if (wrData == reset_pkg::WDT_LOCK) begin
                  st_d.wdtLock = 1'b1;
               end else if (!wrData[7]) begin
                  st_d.interval = wrData[2:0];
               end
            end
            reset_pkg::OFS_RESET_SOURCE: begin
               st_d.compEn = wrData[reset_pkg::BIT_COMPARATOR];
               st_d.cnvEn  = wrData[reset_pkg::BIT_CONVERT];
               if (wrData[reset_pkg::BIT_POWER_FLAG]) begin
                  st_d.supCnt = SUP_W'(SUPPLY_TICKS);
               end
            end
            reset_pkg::OFS_OSCILLATOR_CTRL: begin
               st_d.detEn = wrData[reset_pkg::BIT_CLK_DET_EN];
            end
            default: begin
               st_d.armCnt = st_d.armCnt;
            end
         endcase
      end

      // Sequencer: gather causes, publish them on release
      case (st_q.phase)
         reset_pkg::PH_RUN: begin
            if (anySrc) begin
               st_d.phase = reset_pkg::PH_RESET;
               st_d.pend  = srcNow;
            end
         end
         reset_pkg::PH_RESET: begin
            st_d.pend = st_q.pend | srcNow;
            if (!anySrc) begin
               st_d.phase = reset_pkg::PH_RUN;
               st_d.flags = st_q.pend;
            end
         end
         default: begin
            st_d.phase = reset_pkg::PH_RESET;
         end
      endcase

      // Every reset restores the watchdog and clears detect enable
      if (inRst || anySrc) begin
         st_d.wdtEn    = 1'b1;
         st_d.wdtCnt   = '0;
         st_d.interval = reset_pkg::WDT_INTERVAL_RST;
         st_d.wdtLock  = 1'b0;
         st_d.armCnt   = 3'h0;
         st_d.detEn    = 1'b0;
      end
      // Supply reset also drops the source enables
      if (supplyLow || pinDriven) begin
         st_d.compEn = 1'b0;
         st_d.cnvEn  = 1'b0;
      end
   end

   // State register; power-on starts the supply timeout
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q          <= '0;
         st_q.phase    <= reset_pkg::PH_RESET;
         st_q.supCnt   <= SUP_W'(SUPPLY_TICKS);
         st_q.pend     <= reset_pkg::FLAGS_RST;
         st_q.flags    <= reset_pkg::FLAGS_RST;
         st_q.wdtEn    <= 1'b1;
         st_q.interval <= reset_pkg::WDT_INTERVAL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs; comparator term bypasses all flops
   assign coreReset  = (st_q.phase == reset_pkg::PH_RESET) |
                       cmpReset;
   assign rstPinOut  = 1'b0;
   assign rstPinOe   = pinDriven;
   assign wbRsp      = '{ack: st_q.ack, dat: st_q.rdData};

   // Helper for the restart check: any reset cause this cycle
   logic anyPulse;
   assign anyPulse = (srcNow != 8'h00) | (st_q.evtCnt != 4'h0);

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   supply_pin_a: assert property (supplyLow
      |=> rstPinOe && coreReset)
      else $error("Supply low did not drive pin and reset");
   pin_enter_a: assert property (pinLow |=> coreReset)
      else $error("Pin low did not reset core");
   pin_hold_a: assert property ($rose(rstPinIn)
      && !$past(rstPinOe)
      |=> coreReset [*8] ##1 coreReset [*4])
      else $error("Pin reset released too early");
   pin_flag_a: assert property ($past(st_q.phase)
      == reset_pkg::PH_RESET
      && st_q.phase == reset_pkg::PH_RUN && $past(st_q.pend[0])
      |-> st_q.flags[0])
      else $error("Pin flag not set on exit");
   loss_reset_a: assert property (lossEvt
      |=> coreReset ##1 coreReset)
      else $error("Clock loss did not reset");
   cmp_reset_a: assert property (cmpReset
      |-> coreReset ##1 st_q.phase == reset_pkg::PH_RESET)
      else $error("Comparator reset not immediate");
   cnv_level_a: assert property (cnvReset |=> coreReset)
      else $error("Convert-start low did not reset");
   wdt_restart_a: assert property (wrByte
      && wbReq.adr == reset_pkg::OFS_WATCHDOG_CONTROL
      && wrData == reset_pkg::WDT_RESTART && !coreReset && !anyPulse
      |=> st_q.wdtEn && st_q.wdtCnt == '0)
      else $error("Restart code did not restart watchdog");
   wdt_lock_a: assert property (st_q.wdtLock
      && st_q.wdtEn |=> st_q.wdtEn)
      else $error("Locked watchdog was disabled");
   wdt_default_a: assert property ($fell(coreReset)
      |-> st_q.wdtEn && st_q.interval == reset_pkg::WDT_INTERVAL_RST)
      else $error("Watchdog not at default after reset");

   pin_exit_c: cover property (st_q.flags[0]
      && $rose(st_q.phase == reset_pkg::PH_RUN));
   wdt_over_c: cover property (wdtEvt);
   wdt_off_c: cover property ($fell(st_q.wdtEn));
endmodule
`default_nettype wire

// ---- hdl/reset_pkg.sv ----
/*
 * Constants, register map and bus carriers for the reset source
 * combiner and watchdog.
 * Assumes a single 125 MHz clock and a classic Wishbone register bus.
 */
`default_nettype none
package reset_pkg;
   // Clock rate and derived timing
   localparam int CLOCK_HZ          = 125_000_000; // Reference clock rate
   localparam int SUPPLY_TIMEOUT_MS = 100;   // Supply settle time in ms
   localparam int SUPPLY_CYCLES     =
      SUPPLY_TIMEOUT_MS * (CLOCK_HZ / 1000);  // Supply timeout in cycles
   localparam int CLK_LOSS_US       = 100;   // Clock-loss limit in us
   localparam int CLK_LOSS_CYCLES   =
      CLK_LOSS_US * (CLOCK_HZ / 1_000_000);   // Clock-loss limit in cycles
   localparam logic [3:0] PIN_HOLD  = 4'hC;  // Cycles held after pin rises
   localparam logic [2:0] DISABLE_WINDOW = 3'h4; // Cycles from DE to AD

   // Register byte offsets
   localparam logic [7:0] OFS_WATCHDOG_CONTROL = 8'h00;
   localparam logic [7:0] OFS_RESET_SOURCE     = 8'h04;
   localparam logic [7:0] OFS_OSCILLATOR_CTRL  = 8'h08;

   // Reset source register bit positions
   localparam int BIT_PIN_FLAG    = 0;
   localparam int BIT_POWER_FLAG  = 1;
   localparam int BIT_CLKLOSS     = 2;
   localparam int BIT_WATCHDOG    = 3;
   localparam int BIT_COMPARATOR  = 5;
   localparam int BIT_CONVERT     = 6;
   // Oscillator control: clock-loss detect enable
   localparam int BIT_CLK_DET_EN  = 7;

   // Watchdog control codes and reset values
   localparam logic [7:0] WDT_RESTART = 8'hA5;
   localparam logic [7:0] WDT_DIS_1   = 8'hDE;
   localparam logic [7:0] WDT_DIS_2   = 8'hAD;
   localparam logic [7:0] WDT_LOCK    = 8'hFF;
   localparam logic [2:0] WDT_INTERVAL_RST = 3'h7;
   localparam int WDT_BITS = 21;             // Watchdog counter width
   localparam int WDT_BASE_EXP = 3;          // Timeout is 4^(3+n) ticks

   // Reset values of the source flags
   localparam logic [7:0] FLAGS_RST = 8'h02;

   // Wishbone request and answer carriers
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // Sequencer phase
   typedef enum logic {PH_RUN, PH_RESET} phase_t;
endpackage
`default_nettype wire

// ---- verif/reset_partner.sv ----
/*
 * Model of the far side: supply monitor, reset pin with pull-up,
 * comparator, convert-start pin and the system clock tick source.
 * Assumes the bench commands it by levels changed after a clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module reset_partner (
   input  wire logic clock,         // Reference clock
   input  wire logic rst,           // Power-on reset
   input  wire logic tickOn,        // Run the system clock
   input  wire logic pullPin,       // Outside circuit pulls pin low
   input  wire logic compCmd,       // Comparator plus below minus
   input  wire logic convCmd,       // Convert-start held low
   input  wire logic supplyCmd,     // Supply below threshold
   input  wire logic rstPinOut,     // Block pin value
   input  wire logic rstPinOe,      // Block pin enable
   output var  logic sysClkTick,    // One pulse per system clock edge
   output logic      supplyLow,     // Supply monitor level
   output logic      rstPinIn,      // Resolved pin level
   output logic      compPlusBelow, // Comparator output
   output logic      convStartIn    // Convert-start pin level
);
   // System clock at half the reference rate; stands still when off
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sysClkTick <= 1'b0;
      end else begin
         sysClkTick <= tickOn & ~sysClkTick;
      end
   end
   // Open-drain pin with pull-up: low if either party pulls
   assign rstPinIn = (rstPinOe & ~rstPinOut) ? 1'b0 : ~pullPin;
   assign supplyLow = supplyCmd;
   // Output is quiet until commanded, so no turn-on chatter
   assign compPlusBelow = compCmd;
   // Pin routing is fixed here, so the level is always seen
   assign convStartIn = ~convCmd;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
/*
 * Self-checking bench for the reset source combiner and watchdog.
 * Assumes reset_pkg, reset_sources and reset_partner are compiled.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int LOSS = 20;          // Short clock-loss limit
   localparam int SUP  = 50;          // Short supply timeout
   logic               clock;         // Reference clock
   logic               rst;           // Power-on reset
   reset_pkg::wb_req_t wbReq;         // Bus request
   reset_pkg::wb_rsp_t wbRsp;         // Bus answer
   logic               sysClkTick;    // System clock tick
   logic               supplyLow;     // Supply level
   logic               rstPinIn;      // Pin level
   logic               rstPinOut;     // Pin value
   logic               rstPinOe;      // Pin enable
   logic               compPlusBelow; // Comparator output
   logic               convStartIn;   // Convert-start level
   logic               coreReset;     // Controller reset
   logic               tickOn, pullPin, compCmd, convCmd, supplyCmd;
   int                 oeCnt = 0;     // Cycles with the pin driven
   int                 oeMark;        // Count saved at the start of a check
   logic [31:0]        rng;           // Random state
   logic [31:0]        rd;            // Read data
   int                 miscompares;   // Mismatch count
   int                 checks;        // Comparison count
   int                 n;             // Cycle or tick count
   int                 intervalQ[$];  // Model of written intervals

   reset_sources #(.SUPPLY_TICKS(SUP), .LOSS_TICKS(LOSS)) DUT (
      .clock(clock), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp),
      .sysClkTick(sysClkTick), .supplyLow(supplyLow),
      .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
      .compPlusBelow(compPlusBelow), .convStartIn(convStartIn),
      .coreReset(coreReset));
   reset_partner far (
      .clock(clock), .rst(rst), .tickOn(tickOn), .pullPin(pullPin),
      .compCmd(compCmd), .convCmd(convCmd), .supplyCmd(supplyCmd),
      .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
      .sysClkTick(sysClkTick), .supplyLow(supplyLow),
      .rstPinIn(rstPinIn), .compPlusBelow(compPlusBelow),
      .convStartIn(convStartIn));

   // Clock generator
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Count cycles in which the block drives the pin
   always @(posedge clock) begin
      if (rstPinOe === 1'b1) oeCnt <= oeCnt + 1;
   end

   // Xorshift step
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Verdict and end of run
   task automatic print_verdict();
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Compare seen with expected
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   // One classic Wishbone cycle, waits for ack under a bound
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [7:0] d, output logic [31:0] q);
      int i;
      @(posedge clock);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF,
                 dat: {24'h000000, d}};
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (wbRsp.ack === 1'b1) break;
      end
      q = wbRsp.dat;
      wbReq <= '0;
      if (i == 20) begin
         miscompares++;
         print_verdict();
      end
   endtask
   // Wait until reset reaches a level, counting edges
   task automatic waitCore(input logic lvl, input int bound, output int c);
      for (c = 0; c < bound; c++) begin
         @(posedge clock);
         if (coreReset === lvl) return;
      end
      miscompares++;
      print_verdict();
   endtask
   // Run the system clock and count ticks until the watchdog fires
   task automatic wdRun(input int bound, output int c);
      int i;
      c = 0;
      tickOn <= 1'b1;
      for (i = 0; i < bound; i++) begin
         @(posedge clock);
         if (coreReset === 1'b1) break;
         if (sysClkTick === 1'b1) c++;
      end
      tickOn <= 1'b0;
   endtask
   // Wait for reset exit and compare the cause flags
   task automatic flags(input logic [7:0] exp);
      int c;
      waitCore(1'b0, 400, c);
      wb(1'b0, reset_pkg::OFS_RESET_SOURCE, 8'h00, rd);
      check(rd, {24'h000000, exp});
   endtask

   // Main sequence
   initial begin
      rst = 1'b1; wbReq = '0; tickOn = 0; pullPin = 0; compCmd = 0;
      convCmd = 0; supplyCmd = 0; oeMark = 0; rng = 32'd46516;
      miscompares = 0; checks = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      flags(8'h02);
      wb(1'b0, reset_pkg::OFS_WATCHDOG_CONTROL, 8'h00, rd);
      check(rd, 32'h7);
      // Random interval writes with the top bit clear read back
      repeat (4) begin
         rng = xs(rng);
         intervalQ.push_back(int'(rng[2:0]));
         wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL,
            {1'b0, rng[6:0]}, rd);
         wb(1'b0, reset_pkg::OFS_WATCHDOG_CONTROL, 8'h00, rd);
         check(rd, intervalQ.pop_front());
      end
      // Unmapped place: write ignored, reads zero
      wb(1'b1, 8'h0C, 8'h5A, rd);
      wb(1'b0, 8'h0C, 8'h00, rd);
      check(rd, 32'h0);
      // Timeout for the two shortest intervals
      for (int j = 0; j < 2; j++) begin
         wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'(j), rd);
         wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'hA5, rd);
         oeMark = oeCnt;
         wdRun(2 * (4 ** (3 + j)) + 20, n);
         check(n >= 4 ** (3 + j) - 1 &&
               n <= 4 ** (3 + j) + 1, 1);
         flags(8'h08);
         check(oeCnt - oeMark, 0);
         wb(1'b0, reset_pkg::OFS_WATCHDOG_CONTROL, 8'h00, rd);
         check(rd, 32'h7);
      end
      // Timely disable holds off the reset, restart enables again
      wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'h00, rd);
      wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'hDE, rd);
      wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'hAD, rd);
      wdRun(300, n);
      check(coreReset, 0);
      wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'hA5, rd);
      wdRun(200, n);
      check(n >= 63 && n <= 65, 1);
      flags(8'h08);
      // Late second code, then lockout: both leave the watchdog on
      for (int j = 0; j < 2; j++) begin
         wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'h00, rd);
         if (j == 1) begin
            wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'hFF, rd);
         end
         wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'hDE, rd);
         if (j == 0) repeat (6) @(posedge clock);
         wb(1'b1, reset_pkg::OFS_WATCHDOG_CONTROL, 8'hAD, rd);
         wdRun(200, n);
         check(n >= 63 && n <= 65, 1);
         flags(8'h08);
      end
      // Pin pulled low by the outside circuit
      pullPin <= 1'b1;
      repeat (5) @(posedge clock);
      check(coreReset, 1);
      pullPin <= 1'b0;
      waitCore(1'b0, 100, n);
      check(n >= 12, 1);
      flags(8'h01);
      // Clock-loss detector idle until enabled
      oeMark = oeCnt;
      repeat (3 * LOSS) @(posedge clock);
      check(coreReset, 0);
      wb(1'b1, reset_pkg::OFS_OSCILLATOR_CTRL, 8'h80, rd);
      waitCore(1'b1, LOSS + 10, n);
      check(n <= LOSS + 4, 1);
      flags(8'h04);
      check(oeCnt - oeMark, 0);
      wb(1'b0, reset_pkg::OFS_OSCILLATOR_CTRL, 8'h00, rd);
      check(rd, 32'h0);
      // Comparator reset acts without waiting for a clock edge
      wb(1'b1, reset_pkg::OFS_RESET_SOURCE, 8'h20, rd);
      @(posedge clock);
      compCmd <= 1'b1;
      #1 check(coreReset, 1);
      repeat (3) @(posedge clock);
      compCmd <= 1'b0;
      flags(8'h20);
      // Convert-start is level sensitive
      wb(1'b1, reset_pkg::OFS_RESET_SOURCE, 8'h40, rd);
      convCmd <= 1'b1;
      repeat (2) @(posedge clock);
      repeat (15) begin
         @(posedge clock);
         check(coreReset, 1);
      end
      convCmd <= 1'b0;
      flags(8'h40);
      check(oeCnt - oeMark, 0);
      wb(1'b1, reset_pkg::OFS_RESET_SOURCE, 8'h00, rd);
      // Supply failure drives the pin through the supply timeout
      supplyCmd <= 1'b1;
      repeat (3) @(posedge clock);
      check(coreReset, 1);
      check(rstPinIn, 0);
      supplyCmd <= 1'b0;
      waitCore(1'b0, 300, n);
      check(n >= SUP, 1);
      flags(8'h02);
      // Software-forced power sequence
      oeMark = oeCnt;
      wb(1'b1, reset_pkg::OFS_RESET_SOURCE, 8'h02, rd);
      flags(8'h02);
      check(oeCnt > oeMark, 1);
      print_verdict();
   end
endmodule
`default_nettype wire
